//--- dual_adc_readout.v
// serial readout, register write and offset calibration of the dual converter
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dual_adc_map.vh"
module dual_adc_readout (
	// clock and reset
	input  wire        clk_i,
	input  wire        srst_i,
	// serial link pins
	input  wire        sclk_i,
	input  wire        cs_n_i,
	input  wire        serial_data_in_i,
	input  wire        cal_req_i,
	output reg         result_out_a_o,
	output reg         result_out_a_oe_o,
	output reg         result_out_b_o,
	output reg         result_out_b_oe_o,
	// converter core
	input  wire [11:0] conv_a_i,
	input  wire [11:0] conv_b_i,
	output reg         track_hold_o,
	output reg         short_inputs_o,
	output wire [3:0]  gain_sel_o,
	output wire [2:0]  power_mode_o,
	// register bus
	input  wire [4:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o
);

	// setup time in clocks, cut to the width of its counter
	localparam integer CAL_SETUP_INT = `CAL_SETUP_CYC;
	localparam [7:0]   CAL_SETUP_CYC = CAL_SETUP_INT[7:0];

	// filtered pins
	wire       sclk_s;
	wire       cs_n_s;
	wire       din_s;
	wire       cal_s;

	// edge detection
	reg        sclk_d_r;
	reg        cs_n_d_r;
	reg        cal_d_r;
	wire       sclk_fall;
	wire       cs_fall;
	wire       edge_ok;
	wire [5:0] edge_n;

	// frame state
	reg  [5:0]  cnt_r;
	reg  [11:0] samp_a_r;
	reg  [11:0] samp_b_r;
	reg         cal_run_r;
	reg         cal_by_bit_r;
	reg         cal_inacc_r;
	reg         corrupt_r;
	reg  [7:0]  cal_hi_cnt_r;

	// registers and shifters
	reg  [11:0] ctrl_r;
	reg  [11:0] ofs_a_r;
	reg  [11:0] ofs_b_r;
	reg  [15:0] wsh_r;
	reg  [23:0] sh_a_r;
	reg  [23:0] sh_b_r;
	reg  [11:0] last_a_r;
	reg  [11:0] last_b_r;
	reg  [11:0] load_a;
	wire [11:0] res_a;
	wire [11:0] res_b;
	wire        av_wr;
	wire        cal_bit_wr;

	// subtract a sign-magnitude offset with its magnitude limited, saturating
	function [11:0] off_apply;
		input [11:0] raw;
		input [11:0] code;
		reg   [10:0] mag;
		reg   [13:0] d;
		begin
			mag = (code[10:0] > `OFS_LIMIT) ? `OFS_LIMIT : code[10:0];
			if (code[11])
				d = {{2{raw[11]}}, raw} + {3'h0, mag};
			else
				d = {{2{raw[11]}}, raw} - {3'h0, mag};
			if (d[13:11] == 3'h0 || d[13:11] == 3'h7)
				off_apply = d[11:0];
			else
				off_apply = d[13] ? 12'h800 : 12'h7FF;
		end
	endfunction

	// turn a two's complement shorted-input code into a limited offset code
	function [11:0] to_offset;
		input [11:0] raw;
		reg   [11:0] mag;
		begin
			mag = raw[11] ? (~raw + 12'h001) : raw;
			if (mag > {1'b0, `OFS_LIMIT})
				mag = {1'b0, `OFS_LIMIT};
			to_offset = {raw[11], mag[10:0]};
		end
	endfunction

	// synchronise all link pins
	pin_sync3 #(
		.W       (4),
		.RST_VAL (4'hC)
	) u_sync (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.pin_i   ({sclk_i, cs_n_i, serial_data_in_i, cal_req_i}),
		.level_o ({sclk_s, cs_n_s, din_s, cal_s})
	);

	// edge strobes of the filtered pins
	assign sclk_fall = sclk_d_r & ~sclk_s;
	assign cs_fall   = cs_n_d_r & ~cs_n_s;
	assign edge_ok   = sclk_fall & ~cs_n_s & ~cs_fall;
	assign edge_n    = cnt_r + 6'h01;

	// corrected results and control fields
	assign res_a        = off_apply(samp_a_r, ofs_a_r);
	assign res_b        = off_apply(samp_b_r, ofs_b_r);
	assign gain_sel_o   = ctrl_r[`CTRL_GAIN_HI:`CTRL_GAIN_LO];
	assign power_mode_o = ctrl_r[`CTRL_PD_HI:`CTRL_PD_LO];
	assign av_wr        = avs_write_i & ~avs_waitrequest_o;
	assign cal_bit_wr   = (edge_ok && edge_n == `EDGE_COMMIT
		&& wsh_r[15:12] == `SADDR_CTRL && wsh_r[`CTRL_CAL_BIT])
		|| (av_wr && avs_address_i == `AV_CTRL && avs_writedata_i[`CTRL_CAL_BIT]);

	// readback mux for line A
	always @*
	begin
		case (ctrl_r[`CTRL_RSEL_HI:`CTRL_RSEL_LO])
			`RSEL_RESULT: load_a = res_a;
			`RSEL_CTRL:   load_a = ctrl_r;
			`RSEL_OFS_A:  load_a = ofs_a_r;
			`RSEL_OFS_B:  load_a = ofs_b_r;
			default:      load_a = 12'h000;
		endcase
	end

	// delayed pin levels for edge detection
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			sclk_d_r <= 1'b1;
			cs_n_d_r <= 1'b1;
			cal_d_r  <= 1'b0;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
			cal_d_r  <= cal_s;
		end
	end

	// falling edge counter of the frame
	always @(posedge clk_i)
	begin
		if (srst_i)
			cnt_r <= 6'h00;
		else if (cs_n_s)
			cnt_r <= 6'h00;
		else if (edge_ok && cnt_r != `EDGE_SAT)
			cnt_r <= edge_n;
	end

	// how long the calibration pin has stood high
	always @(posedge clk_i)
	begin
		if (srst_i)
			cal_hi_cnt_r <= 8'h00;
		else if (!cal_s)
			cal_hi_cnt_r <= 8'h00;
		else if (cal_hi_cnt_r != CAL_SETUP_CYC)
			cal_hi_cnt_r <= cal_hi_cnt_r + 8'h01;
	end

	// conversion and calibration sequencing
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			track_hold_o   <= 1'b0;
			short_inputs_o <= 1'b0;
			samp_a_r       <= 12'h000;
			samp_b_r       <= 12'h000;
			cal_run_r      <= 1'b0;
			cal_by_bit_r   <= 1'b0;
			cal_inacc_r    <= 1'b0;
		end
		else if (cs_fall)
		begin
			track_hold_o   <= 1'b1;
			samp_a_r       <= conv_a_i;
			samp_b_r       <= conv_b_i;
			cal_run_r      <= cal_s | ctrl_r[`CTRL_CAL_BIT];
			short_inputs_o <= cal_s | ctrl_r[`CTRL_CAL_BIT];
			cal_by_bit_r   <= ctrl_r[`CTRL_CAL_BIT];
			cal_inacc_r    <= cal_s && (cal_hi_cnt_r < CAL_SETUP_CYC);
		end
		else if (cs_n_s || (edge_ok && edge_n == `EDGE_CONV_DONE))
		begin
			track_hold_o   <= 1'b0;
			short_inputs_o <= 1'b0;
			cal_run_r      <= 1'b0;
		end
	end

	// result line drivers and shifters
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			result_out_a_o    <= 1'b0;
			result_out_b_o    <= 1'b0;
			result_out_a_oe_o <= 1'b0;
			result_out_b_oe_o <= 1'b0;
			sh_a_r            <= 24'h000000;
			sh_b_r            <= 24'h000000;
			last_a_r          <= 12'h000;
			last_b_r          <= 12'h000;
		end
		else if (cs_n_s)
		begin
			result_out_a_oe_o <= 1'b0;
			result_out_b_oe_o <= 1'b0;
		end
		else if (edge_ok)
		begin
			// lines stay off until the conversion edge
			if (edge_n == `EDGE_CONV_DONE)
			begin
				result_out_a_oe_o <= 1'b1;
				result_out_b_oe_o <= 1'b1;
				result_out_a_o    <= load_a[11];
				result_out_b_o    <= res_b[11];
				sh_a_r            <= {load_a[10:0], res_b, 1'b0};
				sh_b_r            <= {res_b[10:0], res_a, 1'b0};
				last_a_r          <= res_a;
				last_b_r          <= res_b;
			end
			// rest of own word, other word, then zero fill
			else if (edge_n > `EDGE_CONV_DONE && edge_n <= `EDGE_LAST_SHIFT)
			begin
				result_out_a_o <= sh_a_r[23];
				result_out_b_o <= sh_b_r[23];
				sh_a_r         <= {sh_a_r[22:0], 1'b0};
				sh_b_r         <= {sh_b_r[22:0], 1'b0};
			end
			// chained readout releases both lines
			else if (edge_n == `EDGE_CHAIN_END)
			begin
				result_out_a_oe_o <= 1'b0;
				result_out_b_oe_o <= 1'b0;
			end
		end
	end

	// registers written from the link, the bus and calibration
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ctrl_r    <= `CTRL_RST;
			ofs_a_r   <= `OFS_RST;
			ofs_b_r   <= `OFS_RST;
			wsh_r     <= 16'h0000;
			corrupt_r <= 1'b0;
		end
		else
		begin
			if (edge_ok && edge_n <= `EDGE_WR_LAST)
				wsh_r <= {wsh_r[14:0], din_s};
			// calibration finishes at the end of its conversion
			if (edge_ok && edge_n == `EDGE_CONV_DONE && cal_run_r)
			begin
				ofs_a_r <= to_offset(samp_a_r);
				ofs_b_r <= to_offset(samp_b_r);
				if (cal_by_bit_r)
					ctrl_r[`CTRL_CAL_BIT] <= 1'b0;
			end
			// serial write commits one edge after its last data bit
			if (edge_ok && edge_n == `EDGE_COMMIT)
			begin
				case (wsh_r[15:12])
					`SADDR_CTRL:  ctrl_r  <= wsh_r[11:0];
					`SADDR_OFS_A: ofs_a_r <= wsh_r[11:0];
					`SADDR_OFS_B: ofs_b_r <= wsh_r[11:0];
					default:      ;
				endcase
			end
			// bus writes
			if (av_wr)
			begin
				case (avs_address_i)
					`AV_CTRL:  ctrl_r  <= avs_writedata_i[11:0];
					`AV_OFS_A: ofs_a_r <= avs_writedata_i[11:0];
					`AV_OFS_B: ofs_b_r <= avs_writedata_i[11:0];
					default:   ;
				endcase
			end
			// corruption flag, cleared per frame, set wins
			if (cs_fall)
				corrupt_r <= 1'b0;
			// a request on the frame start edge does not mark it, hold is not yet set
			if (track_hold_o && ((cal_s && !cal_d_r) || cal_bit_wr))
				corrupt_r <= 1'b1;
		end
	end

	// bus slave: one wait cycle, then answer
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h00000000;
		end
		else
		begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
			case (avs_address_i)
				`AV_CTRL:   avs_readdata_o <= {20'h00000, ctrl_r};
				`AV_OFS_A:  avs_readdata_o <= {20'h00000, ofs_a_r};
				`AV_OFS_B:  avs_readdata_o <= {20'h00000, ofs_b_r};
				`AV_STATUS: avs_readdata_o <= {27'h0000000, corrupt_r, cal_inacc_r,
					cal_run_r, result_out_a_oe_o, track_hold_o};
				`AV_RES_A:  avs_readdata_o <= {20'h00000, last_a_r};
				`AV_RES_B:  avs_readdata_o <= {20'h00000, last_b_r};
				default:    avs_readdata_o <= 32'h00000000;
			endcase
		end
	end

endmodule
`default_nettype wire

//--- dual_adc_map.vh
// constants and field layout of the dual converter readout and offset calibration block
// Operation
// - frame select fall holds inputs, starts conversion
// - result lines stay off while converting
// - 19th falling edge: back to track, lines on
// - 12-bit words, MSB first, one line each
// - MSB on edge 19, LSB on edge 30
// - frame select rise turns lines off
// - 12 more clocks give other channel's word
// - chained: line off at edge 47 or rise
// - edge coinciding with frame fall not counted
// - calibration pin high calibrates next frame
// - pin held high keeps calibrating every frame
// - too-late pin rise flags that calibration inaccurate
// - calibration done at edge 19, then normal
// - control calibration bit starts calibration, corrupts current
// - calibration shorts inputs, stores offset, subtracts later
// - gain change leaves stored offset applied
// - correctable offset limited to 128 LSBs
// - offset registers accept host-written 12-bit codes
// - write frame: 4 address, 12 data, commit 17
// - control bit 7 requests calibration
// - all registers clear to zero at reset
`ifndef DUAL_ADC_MAP_VH
`define DUAL_ADC_MAP_VH

// serial register addresses
`define SADDR_CTRL      4'h1
`define SADDR_OFS_A     4'h2
`define SADDR_OFS_B     4'h3

// read select codes
`define RSEL_RESULT     4'h0
`define RSEL_CTRL       4'h1
`define RSEL_OFS_A      4'h2
`define RSEL_OFS_B      4'h3

// control register fields
`define CTRL_RSEL_HI    11
`define CTRL_RSEL_LO    8
`define CTRL_CAL_BIT    7
`define CTRL_PD_HI      6
`define CTRL_PD_LO      4
`define CTRL_GAIN_HI    3
`define CTRL_GAIN_LO    0

// reset values
`define CTRL_RST        12'h000
`define OFS_RST         12'h000

// frame edge numbers
`define EDGE_WR_LAST    6'h10
`define EDGE_COMMIT     6'h11
`define EDGE_CONV_DONE  6'h13
`define EDGE_LAST_SHIFT 6'h2E
`define EDGE_CHAIN_END  6'h2F
`define EDGE_SAT        6'h3F

// offset limits
`define OFS_LIMIT       11'h080

// calibration setup time and its cycle count at the system clock
`define CLK_MHZ         20
`define CAL_SETUP_NS    100
`define CAL_SETUP_CYC   ((`CAL_SETUP_NS * `CLK_MHZ + 999) / 1000)

// bus byte addresses
`define AV_CTRL         5'h00
`define AV_OFS_A        5'h04
`define AV_OFS_B        5'h08
`define AV_STATUS       5'h0C
`define AV_RES_A        5'h10
`define AV_RES_B        5'h14

`endif

//--- pin_sync3.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
	parameter       W       = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         srst_i,
	// pins in, filtered levels out
	input  wire [W-1:0] pin_i,
	output reg  [W-1:0] level_o
);

	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	integer     k;

	// three stages, output moves only where stages two and three agree
	always @(posedge clk_i)
	begin
		if (srst_i)
		begin
			s1_r    <= RST_VAL;
			s2_r    <= RST_VAL;
			s3_r    <= RST_VAL;
			level_o <= RST_VAL;
		end
		else
		begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (k = 0; k < W; k = k + 1)
				if (s2_r[k] == s3_r[k])
					level_o[k] <= s3_r[k];
		end
	end

endmodule
`default_nettype wire

//--- dual_adc_readout_asserts.sv
// assertion checker bound to the dual converter readout ports
`timescale 1ns/1ns
`default_nettype none
module dual_adc_readout_asserts (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// observed pins
	input  wire logic cs_n_i,
	input  wire logic cal_req_i,
	input  wire logic result_out_a_oe_o,
	input  wire logic result_out_b_oe_o,
	input  wire logic track_hold_o,
	input  wire logic short_inputs_o,
	input  wire logic avs_read_i,
	input  wire logic avs_waitrequest_o
);
	logic [7:0] low_cnt_r;

	// clocks elapsed since frame select fell
	always @(posedge clk_i)
		if (srst_i || cs_n_i)
			low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hFF)
			low_cnt_r <= low_cnt_r + 8'h01;

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_hold_start: assert property ($fell(cs_n_i) |-> ##[2:6] track_hold_o)
		else $error("hold not entered after frame select fell");
	a_oe_late: assert property ($rose(result_out_a_oe_o) |-> low_cnt_r >= 8'h26)
		else $error("line enabled too early in the frame");
	a_oe_pair: assert property ($rose(result_out_a_oe_o) |-> $rose(result_out_b_oe_o))
		else $error("lines not enabled together");
	a_off_conv: assert property (track_hold_o |-> !result_out_a_oe_o && !result_out_b_oe_o)
		else $error("line driven while converting");
	a_off_idle: assert property (cs_n_i && $past(cs_n_i, 6) |-> !result_out_a_oe_o && !result_out_b_oe_o)
		else $error("line still driven after frame end");
	a_short_hold: assert property (short_inputs_o |-> track_hold_o)
		else $error("inputs shorted outside a conversion");
	a_cal_short: assert property ($fell(cs_n_i) && cal_req_i |-> ##[2:6] short_inputs_o)
		else $error("calibration not started by request pin");
	a_reset_quiet: assert property ($fell(srst_i) |-> !result_out_a_oe_o && !track_hold_o
		&& avs_waitrequest_o)
		else $error("outputs not quiet after reset");
	a_wait_once: assert property ($rose(avs_read_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("waitrequest not low for one cycle");
endmodule

bind dual_adc_readout dual_adc_readout_asserts u_chk (.clk_i, .srst_i, .cs_n_i, .cal_req_i,
	.result_out_a_oe_o, .result_out_b_oe_o, .track_hold_o, .short_inputs_o, .avs_read_i,
	.avs_waitrequest_o);
`default_nettype wire

//--- host_link_model.sv
// host serial master model driving the converter link
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
	// link pins out
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	output logic      cal_req_o,
	// result lines in
	input  wire logic a_i,
	input  wire logic a_oe_i,
	input  wire logic b_i,
	input  wire logic b_oe_i
);
	logic [47:1] capa = '0;
	logic [47:1] capb = '0;

	// link idles with clock high and frame select high
	initial
	begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b0;
		cal_req_o = 1'b0;
	end

	// one frame: shift wr out, capture both lines, released line reads z
	task automatic frame(input int nclk, input logic [15:0] wr, input logic cal, input logic coin);
		cal_req_o <= cal; // pin moves only between frames
		#500;
		cs_n_o <= 1'b0;
		din_o <= wr[15];
		if (coin)
			sclk_o <= 1'b0;
		#200;
		sclk_o <= 1'b1;
		#200;
		for (int n = 1; n <= nclk; n++)
		begin
			sclk_o <= 1'b0;
			#200;
			sclk_o <= 1'b1;
			din_o <= (n < 16) ? wr[15 - n] : 1'b0;
			#200;
			// rising-edge reads only suit a fast core clock; slow link reads late
			capa = {capa[46:1], (a_oe_i ? a_i : 1'bz)}; // read before next fall
			capb = {capb[46:1], (b_oe_i ? b_i : 1'bz)};
		end
		cs_n_o <= 1'b1;
		#600;
	endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the dual converter readout block
`timescale 1ns/1ns
`default_nettype none
`include "dual_adc_map.vh"
module tb_top;
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [11:0] conv_a = 12'h000;
	logic [11:0] conv_b = 12'h000;
	logic [4:0]  addr = 5'h00;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdv;
	wire         sclk, cs_n, din, cal, la, la_oe, lb, lb_oe, track, shorted, wreq;
	wire  [3:0]  gain;
	wire  [2:0]  pwr;
	wire  [31:0] rdata;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          cyc = 0;

	// system clock
	always #25 clk_i = ~clk_i;

	dual_adc_readout u_dut (.clk_i(clk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.serial_data_in_i(din), .cal_req_i(cal), .result_out_a_o(la), .result_out_a_oe_o(la_oe),
		.result_out_b_o(lb), .result_out_b_oe_o(lb_oe), .conv_a_i(conv_a), .conv_b_i(conv_b),
		.track_hold_o(track), .short_inputs_o(shorted), .gain_sel_o(gain), .power_mode_o(pwr),
		.avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq));

	host_link_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .cal_req_o(cal),
		.a_i(la), .a_oe_i(la_oe), .b_i(lb), .b_oe_i(lb_oe));

	task test_done;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			test_done;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// one bus cycle held until waitrequest is sampled low
	task bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		addr <= a;
		wdata <= wd;
		wr_en <= w;
		rd_en <= !w;
		do @(posedge clk_i); while (wreq !== 1'b0);
		rdv = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask

	task setconv(input logic [11:0] a, input logic [11:0] b);
		@(posedge clk_i);
		conv_a <= a;
		conv_b <= b;
	endtask

	task t_reset;
		bus(0, `AV_CTRL, 0);
		check(rdv, 0);
		bus(0, `AV_OFS_A, 0);
		check(rdv, 0);
		bus(0, `AV_OFS_B, 0);
		check(rdv, 0);
		bus(0, 5'h1C, 0);
		check(rdv, 0);
		$display("t_reset done");
	endtask

	task t_plain;
		setconv(12'hA5C, 12'h3B1);
		u_host.frame(31, 16'h0000, 0, 0);
		check(u_host.capa[14], 1'bz);
		check(u_host.capa[13:2], 12'hA5C);
		check(u_host.capb[13:2], 12'h3B1);
		u_host.frame(31, 16'h0000, 0, 1);
		check(u_host.capa[13:2], 12'hA5C);
		u_host.frame(47, 16'h0000, 0, 0);
		check(u_host.capa[17:6], 12'h3B1);
		check(u_host.capb[17:6], 12'hA5C);
		check({u_host.capa[1], u_host.capb[1]}, 2'bzz);
		$display("t_plain done");
	endtask

	task t_write;
		setconv(12'h100, 12'h0C3);
		u_host.frame(31, {4'h2, 12'h010}, 0, 0);
		bus(0, `AV_OFS_A, 0);
		check(rdv, 12'h010);
		u_host.frame(31, {4'h1, 12'h200}, 0, 0);
		check(u_host.capa[13:2], 12'h010);
		check(u_host.capb[13:2], 12'h0C3);
		u_host.frame(31, {4'h1, 12'h000}, 0, 0);
		check(u_host.capa[13:2], 12'h0F0);
		$display("t_write done");
	endtask

	task t_ofs;
		bus(1, `AV_OFS_A, 12'h1F4);
		bus(1, `AV_OFS_B, 12'h810);
		setconv(12'h300, 12'h100);
		u_host.frame(31, 16'h0000, 0, 0);
		check(u_host.capa[13:2], 12'h280);
		check(u_host.capb[13:2], 12'h110);
		bus(1, `AV_CTRL, 12'h003); // power bits left at zero
		@(posedge clk_i);
		check(gain, 4'h3);
		check(pwr, 3'h0);
		u_host.frame(31, 16'h0000, 0, 0);
		check(u_host.capa[13:2], 12'h280);
		bus(0, `AV_OFS_A, 0);
		check(rdv, 12'h1F4);
		$display("t_ofs done");
	endtask

	task t_calpin;
		setconv(12'h005, 12'hFFD);
		u_host.frame(31, 16'h0000, 1, 0);
		bus(0, `AV_OFS_B, 0);
		check(rdv, 12'h803);
		bus(0, `AV_STATUS, 0);
		check(rdv[3], 1'b0);
		setconv(12'h007, 12'hFFD);
		u_host.frame(31, 16'h0000, 1, 0);
		bus(0, `AV_OFS_A, 0);
		check(rdv, 12'h007);
		setconv(12'h107, 12'h010);
		u_host.frame(31, 16'h0000, 0, 0);
		check(u_host.capa[13:2], 12'h100);
		check(u_host.capb[13:2], 12'h013);
		$display("t_calpin done");
	endtask

	task t_calbit;
		fork
			u_host.frame(31, 16'h0000, 0, 0);
			begin
				#2000;
				bus(1, `AV_CTRL, 12'h080);
				bus(0, `AV_STATUS, 0);
				check(rdv[4], 1'b1);
			end
		join
		setconv(12'h009, 12'h002);
		u_host.frame(31, 16'h0000, 0, 0);
		bus(0, `AV_OFS_A, 0);
		check(rdv, 12'h009);
		bus(0, `AV_CTRL, 0);
		check(rdv, 12'h000);
		$display("t_calbit done");
	endtask

	initial
	begin
		repeat (5) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reset;
		t_plain;
		t_write;
		t_ofs;
		t_calpin;
		t_calbit;
		test_done;
	end
endmodule
`default_nettype wire
